/* File: logic/limit_switch_positioning.sv */
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "positioning_defines.svh"

module limit_switch_positioning
  import positioning_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic nvRstN,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] sensorPins,
  input wire logic disablePin,
  input wire logic runFwdReq,
  input wire logic runRevReq,
  output logic fwdSlowCmd,
  output logic revSlowCmd,
  output logic fwdStopCmd,
  output logic revStopCmd,
  output logic fwdEnable,
  output logic revEnable,
  output logic [1:0] slowMode,
  output logic [1:0] stopMode
);

  top_state_t s_q;
  top_state_t s_d;
  nv_state_t nv_q;
  nv_state_t nv_d;
  logic rstN;
  logic nvRst;
  logic [3:0] levelAct;
  logic [3:0] actEdge;
  logic [3:0] oppEdge;
  logic [3:0] setReq;
  logic [3:0] clrReq;
  logic [3:0] mineRun;
  logic [3:0] otherRun;
  logic fwdRun;
  logic revRun;
  logic disabled;
  logic longCam;
  logic restore;
  logic [31:0] statusWord;
  // Kept apart from the state struct: each has its own asynchronous reset
  logic [1:0] rstSync_q;
  logic [1:0] nvRstSync_q;

  assign rstN = rstSync_q[1];
  assign nvRst = nvRstSync_q[1];

  // Both resets enter asynchronously and release through two flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end

  always_ff @(posedge clock or negedge nvRstN)
  begin
    if (!nvRstN)
      nvRstSync_q <= 2'h0;
    else
      nvRstSync_q <= {nvRstSync_q[0], 1'b1};
  end

  genvar ch;
  generate
    for (ch = 0; ch < `POS_NUM_CH; ch++)
    begin : g_ch
      position_edge u_edge (
        .clock(clock),
        .rstN(rstN),
        .sensorPin(sensorPins[ch]),
        .wordBit(s_q.cmd[`POS_CMD_BITS_LSB + ch]),
        .useWord(s_q.ctrl[`POS_CTRL_SRC_LSB + ch]),
        .risingActive(s_q.ctrl[`POS_CTRL_POL_LSB + ch]),
        .levelActive(levelAct[ch]),
        .activeEdge(actEdge[ch]),
        .oppositeEdge(oppEdge[ch])
      );
    end
  endgenerate

  // Both commands at once count as no travel, so nothing is latched
  assign fwdRun = s_q.runFwd && !s_q.runRev;
  assign revRun = s_q.runRev && !s_q.runFwd;
  assign disabled = s_q.ctrl[`POS_CTRL_DIS_SRC] ? s_q.cmd[`POS_CMD_DISABLE] : s_q.disPin;
  assign longCam = s_q.ctrl[`POS_CTRL_LONG_CAM];
  assign restore = s_q.ctrl[`POS_CTRL_RESTORE];
  // Forward channels own forward travel, reverse channels mirror it
  assign mineRun = {revRun, fwdRun, revRun, fwdRun};
  assign otherRun = {fwdRun, revRun, fwdRun, revRun};

  // Long cams read the zone level, so any start position initializes
  always_comb
  begin
    for (int i = 0; i < `POS_NUM_CH; i++)
    begin
      setReq[i] = mineRun[i] && (longCam ? levelAct[i] : actEdge[i]);
      clrReq[i] = otherRun[i] && (longCam ? !levelAct[i] : oppEdge[i]);
    end
  end

  // Disable is not consulted here, so tracking goes on while disabled
  always_comb
  begin
    nv_d = nv_q;
    for (int i = 0; i < `POS_NUM_CH; i++)
    begin
      if (setReq[i])
        nv_d.latched[i] = 1'b1;
      else if (clrReq[i] || restore)
        nv_d.latched[i] = 1'b0;
    end
  end

  // Retained domain: only its own power-on reset, the restore bit or opposite travel clears it, never nrst
  always_ff @(posedge clock or negedge nvRst)
  begin
    if (!nvRst)
      nv_q <= '0;
    else
      nv_q <= nv_d;
  end

  assign statusWord = {21'h000000, revRun, fwdRun, disabled, levelAct, nv_q.latched};

  always_comb
  begin
    s_d = s_q;
    s_d.fwdMeta = {s_q.fwdMeta[0], runFwdReq};
    s_d.revMeta = {s_q.revMeta[0], runRevReq};
    s_d.disMeta = {s_q.disMeta[0], disablePin};
    s_d.runFwd = s_q.fwdMeta[1];
    s_d.runRev = s_q.revMeta[1];
    s_d.disPin = s_q.disMeta[1];
    s_d.hreadyout = 1'b1;
    s_d.ctrl[`POS_CTRL_RESTORE] = 1'b0;
    // Zero wait states: read data is chosen in the address phase
    s_d.addrValid = hsel && htrans[1] && hready;
    s_d.addrWrite = hwrite;
    s_d.addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      unique case (haddr[7:0])
        `POS_CTRL_ADDR: s_d.rdata = {17'h00000, s_q.ctrl};
        `POS_CMD_ADDR: s_d.rdata = {27'h0000000, s_q.cmd};
        `POS_STATUS_ADDR: s_d.rdata = statusWord;
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (s_q.addrValid && s_q.addrWrite)
    begin
      if (s_q.addr == `POS_CTRL_ADDR)
        s_d.ctrl = hwdata[14:0];
      else if (s_q.addr == `POS_CMD_ADDR)
        s_d.cmd = hwdata[4:0];
    end
    s_d.slowMode = s_q.ctrl[`POS_CTRL_SLOW_MODE_LSB +: 2];
    s_d.stopMode = s_q.ctrl[`POS_CTRL_STOP_MODE_LSB +: 2];
    // Reverse slowdown alone never slows reverse from a forward latch
    s_d.fwdSlowCmd = nv_q.latched[`POS_CH_FWD_SLOW] && fwdRun && !disabled;
    s_d.revSlowCmd = nv_q.latched[`POS_CH_REV_SLOW] && revRun && !disabled;
    s_d.fwdStopCmd = nv_q.latched[`POS_CH_FWD_STOP] && !disabled;
    s_d.revStopCmd = nv_q.latched[`POS_CH_REV_STOP] && !disabled;
    s_d.fwdEnable = fwdRun && !(nv_q.latched[`POS_CH_FWD_STOP] && !disabled);
    s_d.revEnable = revRun && !(nv_q.latched[`POS_CH_REV_STOP] && !disabled);
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      s_q.fwdMeta <= 2'h0;
      s_q.revMeta <= 2'h0;
      s_q.runFwd <= 1'b0;
      s_q.runRev <= 1'b0;
      s_q.disMeta <= 2'h0;
      s_q.disPin <= 1'b0;
      s_q.addrValid <= 1'b0;
      s_q.addrWrite <= 1'b0;
      s_q.addr <= 8'h00;
      s_q.ctrl <= `POS_CTRL_RESET;
      s_q.cmd <= `POS_CMD_RESET;
      s_q.rdata <= 32'h00000000;
      s_q.hreadyout <= 1'b0;
      s_q.fwdSlowCmd <= 1'b0;
      s_q.revSlowCmd <= 1'b0;
      s_q.fwdStopCmd <= 1'b0;
      s_q.revStopCmd <= 1'b0;
      s_q.fwdEnable <= 1'b0;
      s_q.revEnable <= 1'b0;
      s_q.slowMode <= 2'h0;
      s_q.stopMode <= 2'h0;
    end
    else
    begin
      s_q.fwdMeta <= s_d.fwdMeta;
      s_q.revMeta <= s_d.revMeta;
      s_q.runFwd <= s_d.runFwd;
      s_q.runRev <= s_d.runRev;
      s_q.disMeta <= s_d.disMeta;
      s_q.disPin <= s_d.disPin;
      s_q.addrValid <= s_d.addrValid;
      s_q.addrWrite <= s_d.addrWrite;
      s_q.addr <= s_d.addr;
      s_q.ctrl <= s_d.ctrl;
      s_q.cmd <= s_d.cmd;
      s_q.rdata <= s_d.rdata;
      s_q.hreadyout <= s_d.hreadyout;
      s_q.fwdSlowCmd <= s_d.fwdSlowCmd;
      s_q.revSlowCmd <= s_d.revSlowCmd;
      s_q.fwdStopCmd <= s_d.fwdStopCmd;
      s_q.revStopCmd <= s_d.revStopCmd;
      s_q.fwdEnable <= s_d.fwdEnable;
      s_q.revEnable <= s_d.revEnable;
      s_q.slowMode <= s_d.slowMode;
      s_q.stopMode <= s_d.stopMode;
    end
  end

  assign hreadyout = s_q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign fwdSlowCmd = s_q.fwdSlowCmd;
  assign revSlowCmd = s_q.revSlowCmd;
  assign fwdStopCmd = s_q.fwdStopCmd;
  assign revStopCmd = s_q.revStopCmd;
  assign fwdEnable = s_q.fwdEnable;
  assign revEnable = s_q.revEnable;
  assign slowMode = s_q.slowMode;
  assign stopMode = s_q.stopMode;

  property p_fwd_slow_set;
    @(posedge clock) disable iff (!nvRst || !rstN)
    fwdRun && !longCam && actEdge[`POS_CH_FWD_SLOW] |=> nv_q.latched[`POS_CH_FWD_SLOW];
  endproperty
  a_fwd_slow_set: assert property (p_fwd_slow_set)
    else $error("forward slowdown edge not latched");

  property p_fwd_slow_cause;
    @(posedge clock) disable iff (!nvRst || !rstN)
    $rose(nv_q.latched[`POS_CH_FWD_SLOW]) |-> $past(fwdRun);
  endproperty
  a_fwd_slow_cause: assert property (p_fwd_slow_cause)
    else $error("forward slowdown latched without forward travel");

  property p_fwd_slow_clear;
    @(posedge clock) disable iff (!nvRst || !rstN)
    $fell(nv_q.latched[`POS_CH_FWD_SLOW]) |-> $past(revRun || restore);
  endproperty
  a_fwd_slow_clear: assert property (p_fwd_slow_clear)
    else $error("forward slowdown cleared without reverse travel");

  property p_hold_idle;
    @(posedge clock) disable iff (!nvRst || !rstN)
    !fwdRun && !revRun && !restore |=> $stable(nv_q.latched);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("latched requests changed while stopped");

  property p_rev_allowed;
    @(posedge clock) disable iff (!nvRst || !rstN)
    revRun && !nv_q.latched[`POS_CH_REV_STOP] |=>
      revEnable && (!revSlowCmd || $past(nv_q.latched[`POS_CH_REV_SLOW]));
  endproperty
  a_rev_allowed: assert property (p_rev_allowed)
    else $error("reverse travel blocked by a forward request");

  property p_disable_suppress;
    @(posedge clock) disable iff (!nvRst || !rstN)
    disabled |=> !fwdSlowCmd && !revSlowCmd;
  endproperty
  a_disable_suppress: assert property (p_disable_suppress)
    else $error("slowdown output while disabled");

  property p_disable_tracks;
    @(posedge clock) disable iff (!nvRst || !rstN)
    disabled && fwdRun && !longCam && actEdge[`POS_CH_FWD_SLOW] |=>
      nv_q.latched[`POS_CH_FWD_SLOW];
  endproperty
  a_disable_tracks: assert property (p_disable_tracks)
    else $error("edge lost while disabled");

  property p_long_cam;
    @(posedge clock) disable iff (!nvRst || !rstN)
    longCam && fwdRun && levelAct[`POS_CH_FWD_SLOW] |=> nv_q.latched[`POS_CH_FWD_SLOW];
  endproperty
  a_long_cam: assert property (p_long_cam)
    else $error("long cam zone level not latched");

  property p_stop_refuse;
    @(posedge clock) disable iff (!nvRst || !rstN)
    nv_q.latched[`POS_CH_FWD_STOP] && !disabled |=> !fwdEnable;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse)
    else $error("forward enabled with forward stop latched");

endmodule // limit_switch_positioning

/* File: logic/positioning_defines.svh */
`ifndef POSITIONING_DEFINES_SVH
`define POSITIONING_DEFINES_SVH

// Byte addresses of the register words
`define POS_CTRL_ADDR 8'h00
`define POS_CMD_ADDR 8'h04
`define POS_STATUS_ADDR 8'h08

// Channel numbering, shared by every 4-bit channel field
`define POS_CH_FWD_SLOW 0
`define POS_CH_REV_SLOW 1
`define POS_CH_FWD_STOP 2
`define POS_CH_REV_STOP 3
`define POS_NUM_CH 4

// Control word fields
`define POS_CTRL_POL_LSB 0
`define POS_CTRL_SRC_LSB 4
`define POS_CTRL_LONG_CAM 8
`define POS_CTRL_DIS_SRC 9
`define POS_CTRL_SLOW_MODE_LSB 10
`define POS_CTRL_STOP_MODE_LSB 12
`define POS_CTRL_RESTORE 14
`define POS_CTRL_RESET 15'h000f

// Command word fields
`define POS_CMD_BITS_LSB 0
`define POS_CMD_DISABLE 4
`define POS_CMD_RESET 5'h00

// Status word fields
`define POS_STAT_LATCH_LSB 0
`define POS_STAT_LEVEL_LSB 4
`define POS_STAT_DISABLED 8
`define POS_STAT_RUN_FWD 9
`define POS_STAT_RUN_REV 10

`endif

/* File: logic/positioning_pkg.sv */
package positioning_pkg;

  typedef struct packed {
    logic pinMeta;
    logic pinSync;
    logic prevLevel;
  } edge_state_t;

  typedef struct packed {
    logic [1:0] fwdMeta;
    logic [1:0] revMeta;
    logic runFwd;
    logic runRev;
    logic [1:0] disMeta;
    logic disPin;
    logic addrValid;
    logic addrWrite;
    logic [7:0] addr;
    logic [14:0] ctrl;
    logic [4:0] cmd;
    logic [31:0] rdata;
    logic hreadyout;
    logic fwdSlowCmd;
    logic revSlowCmd;
    logic fwdStopCmd;
    logic revStopCmd;
    logic fwdEnable;
    logic revEnable;
    logic [1:0] slowMode;
    logic [1:0] stopMode;
  } top_state_t;

  // Latched requests, kept in the retained domain
  typedef struct packed {
    logic [3:0] latched;
  } nv_state_t;

endpackage

/* File: logic/position_edge.sv */
`timescale 1ns/1ps
`include "positioning_defines.svh"

module position_edge
  import positioning_pkg::*;
(
  input wire logic clock,
  input wire logic rstN,
  input wire logic sensorPin,
  input wire logic wordBit,
  input wire logic useWord,
  input wire logic risingActive,
  output logic levelActive,
  output logic activeEdge,
  output logic oppositeEdge
);

  edge_state_t s_q;
  edge_state_t s_d;
  logic level;

  // Pin passes two flip-flops; the word bit is already in this domain
  always_comb
  begin
    s_d = s_q;
    s_d.pinMeta = sensorPin;
    s_d.pinSync = s_q.pinMeta;
    s_d.prevLevel = level;
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level = useWord ? wordBit : s_q.pinSync;
  assign levelActive = (level == risingActive);
  assign activeEdge = (level != s_q.prevLevel) && (level == risingActive);
  assign oppositeEdge = (level != s_q.prevLevel) && (level != risingActive);

endmodule // position_edge

/* File: test/position_partner.sv */
`timescale 1ns/1ps
// Sensors and command source; levels move only just after a rising edge
module position_partner (
  input wire logic clock,
  input wire logic [3:0] zoneSet,
  input wire logic [1:0] travelSet,
  input wire logic disableSet,
  output logic [3:0] sensorPins,
  output logic runFwdReq,
  output logic runRevReq,
  output logic disablePin
);
  // Cart starts stopped, clear of every zone; one process drives every pin
  initial
  begin
    sensorPins = 4'h0;
    runFwdReq = 1'b0;
    runRevReq = 1'b0;
    disablePin = 1'b0;
    forever
    begin
      @(posedge clock);
      sensorPins <= zoneSet;
      runFwdReq <= travelSet[0];
      runRevReq <= travelSet[1];
      disablePin <= disableSet;
    end
  end
endmodule // position_partner

/* File: test/limit_switch_positioning_tb_top.sv */
`timescale 1ns/1ps
`include "positioning_defines.svh"
module limit_switch_positioning_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic nvRstN = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] zone = 4'h0;
  logic [1:0] travel = 2'h0;
  logic dis = 1'b0;
  logic hreadyout, hresp, disablePin, runFwdReq, runRevReq;
  logic fwdSlowCmd, revSlowCmd, fwdStopCmd, revStopCmd, fwdEnable, revEnable;
  logic [31:0] hrdata, rd;
  logic [3:0] sensorPins;
  logic [1:0] slowMode, stopMode, m;
  logic [5:0] outs;
  logic [5:0] expOut [4] = '{6'h28, 6'h14, 6'h02, 6'h01};
  int miscompares = 0;
  int nTests = 0;
  assign outs = {fwdEnable, revEnable, fwdSlowCmd, revSlowCmd, fwdStopCmd, revStopCmd};
  initial
  begin
    forever #10 clock = ~clock;
  end
  position_partner u_position_partner (.clock(clock), .zoneSet(zone), .travelSet(travel),
    .disableSet(dis), .sensorPins(sensorPins), .runFwdReq(runFwdReq),
    .runRevReq(runRevReq), .disablePin(disablePin));
  limit_switch_positioning u_limit_switch_positioning (.clock(clock), .nrst(nrst),
    .nvRstN(nvRstN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sensorPins(sensorPins), .disablePin(disablePin),
    .runFwdReq(runFwdReq), .runRevReq(runRevReq), .fwdSlowCmd(fwdSlowCmd),
    .revSlowCmd(revSlowCmd), .fwdStopCmd(fwdStopCmd), .revStopCmd(revStopCmd),
    .fwdEnable(fwdEnable), .revEnable(revEnable), .slowMode(slowMode),
    .stopMode(stopMode));
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One single word transfer; the master holds each phase until hready is high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic st(input logic [31:0] msk, input logic [31:0] exp);
    bus(`POS_STATUS_ADDR, 1'b0, 32'h0);
    check(rd & msk, exp);
  endtask
  // Eight cycles covers the two-flop sync, edge detect, latch and output stage
  task automatic drive(input logic [3:0] z, input logic [1:0] t, input logic d);
    zone <= z;
    travel <= t;
    dis <= d;
    wt(8);
  endtask
  initial
  begin
    #400000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    wt(10);
    nrst <= 1'b1;
    nvRstN <= 1'b1;
    wt(4);
    bus(`POS_CTRL_ADDR, 1'b0, 32'h0);
    check(rd, 32'h0000000f);
    check({31'h0, hresp}, 32'h0);
    bus(8'h0c, 1'b1, 32'hffffffff);
    bus(8'h0c, 1'b0, 32'h0);
    check(rd, 32'h0);
    st(32'hffffffff, 32'h0);
    $display("Test reset done");
    drive(4'h0, 2'h2, 1'b0);
    drive(4'h1, 2'h2, 1'b0);
    st(32'h1, 32'h0);
    drive(4'h0, 2'h1, 1'b0);
    drive(4'h1, 2'h1, 1'b0);
    st(32'h1, 32'h1);
    check({26'h0, outs}, 32'h28);
    drive(4'h1, 2'h2, 1'b0);
    check({26'h0, outs}, 32'h10);
    drive(4'h1, 2'h1, 1'b0);
    drive(4'h0, 2'h1, 1'b0);
    st(32'h1, 32'h1);
    drive(4'h0, 2'h2, 1'b0);
    st(32'h1, 32'h1);
    drive(4'h1, 2'h2, 1'b0);
    drive(4'h0, 2'h2, 1'b0);
    st(32'h1, 32'h0);
    drive(4'h0, 2'h1, 1'b0);
    drive(4'h1, 2'h1, 1'b0);
    // Stop first, so that a fresh sync after reset cannot relatch the request
    drive(4'h1, 2'h0, 1'b0);
    nrst <= 1'b0;
    wt(3);
    nrst <= 1'b1;
    wt(4);
    st(32'h1, 32'h1);
    nvRstN <= 1'b0;
    wt(2);
    nvRstN <= 1'b1;
    wt(4);
    st(32'h1, 32'h0);
    $display("Test forward slowdown done");
    for (int ch = 0; ch < 4; ch++)
    begin
      drive(4'h0, ch[0] ? 2'h2 : 2'h1, 1'b0);
      drive(4'h1 << ch, ch[0] ? 2'h2 : 2'h1, 1'b0);
      st(32'hf, 32'h1 << ch);
      check({26'h0, outs}, {26'h0, expOut[ch]});
      bus(`POS_CTRL_ADDR, 1'b1, 32'h0000400f);
      wt(2);
      st(32'hf, 32'h0);
    end
    $display("Test channels done");
    bus(`POS_CTRL_ADDR, 1'b1, 32'h000000ff);
    drive(4'h0, 2'h1, 1'b0);
    bus(`POS_CMD_ADDR, 1'b1, 32'h1);
    drive(4'h4, 2'h1, 1'b0);
    st(32'h5, 32'h1);
    bus(`POS_CMD_ADDR, 1'b1, 32'h0);
    bus(`POS_CTRL_ADDR, 1'b1, 32'h0000400e);
    drive(4'h1, 2'h0, 1'b0);
    drive(4'h1, 2'h1, 1'b0);
    st(32'h1, 32'h0);
    drive(4'h0, 2'h1, 1'b0);
    st(32'h1, 32'h1);
    $display("Test sources done");
    bus(`POS_CTRL_ADDR, 1'b1, 32'h0000400f);
    drive(4'h0, 2'h1, 1'b1);
    drive(4'h1, 2'h1, 1'b1);
    st(32'h101, 32'h101);
    check({26'h0, outs}, 32'h20);
    drive(4'h1, 2'h1, 1'b0);
    check({26'h0, outs}, 32'h28);
    bus(`POS_CTRL_ADDR, 1'b1, 32'h0000020f);
    bus(`POS_CMD_ADDR, 1'b1, 32'h10);
    wt(8);
    check({26'h0, outs}, 32'h20);
    bus(`POS_CMD_ADDR, 1'b1, 32'h0);
    $display("Test disable done");
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      bus(`POS_CTRL_ADDR, 1'b1, {18'h0, m, ~m, 10'h00f});
      wt(2);
      check({28'h0, slowMode, stopMode}, {28'h0, ~m, m});
    end
    // Restore while stopped, then start inside the zone with no edge at all
    drive(4'h1, 2'h0, 1'b0);
    bus(`POS_CTRL_ADDR, 1'b1, 32'h0000410f);
    wt(2);
    st(32'h1, 32'h0);
    drive(4'h1, 2'h1, 1'b0);
    st(32'h1, 32'h1);
    $display("Test modes and long cams done");
    give_verdict();
  end
endmodule // limit_switch_positioning_tb_top
